// *** rtl/bsio_unit.sv ***
`timescale 1ns/10ps
module bsio_unit (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire bsio_pkg::bsio_cmd_t cmd,
  input wire logic serial_input_line,
  output logic cmd_ready,
  output logic busy,
  output logic [14:0] io_addr,
  output logic serial_output_line,
  output logic output_bit_strobe,
  output logic done,
  output bsio_pkg::bsio_result_t result
);

  typedef enum logic {
    ST_IDLE,
    ST_SLOT
  } bsio_state_t;

  bsio_state_t state;
  bsio_pkg::bsio_op_t op_q;
  logic [2:0] phase;
  logic [4:0] bit_k;
  logic [4:0] last_k;
  logic byte_mode;
  logic [15:0] word_q;
  logic [15:0] collect;
  logic sin_s;

  logic accept;
  logic slot_end;
  logic last_bit;
  logic is_output_op;
  logic is_single_op;
  logic next_byte_mode;
  logic [4:0] next_last_k;
  logic [11:0] hw_base;
  logic [11:0] disp_ext;
  logic [15:0] next_collect;
  logic [4:0] next_k;

  // ****************************************
  // Input synchroniser
  // ****************************************
  // Peripherals give no strobe on input, so the line is treated as asynchronous
  bsio_sync #(
    .WIDTH(1)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .async_in(serial_input_line), // [R18]
    .sync_out(sin_s)
  );

  // ****************************************
  // Decode
  // ****************************************
  // A request while busy is simply not taken; nothing queues
  assign accept = (state == ST_IDLE) && cmd_valid;
  assign slot_end = (state == ST_SLOT) && (phase == bsio_pkg::BSIO_SLOT_LAST_PHASE);
  assign last_bit = (bit_k == last_k);
  assign next_k = bit_k + 5'h01;
  // Ops that put data on the serial output and want the strobe
  assign is_output_op = (op_q == bsio_pkg::multibit_load_op) ||
                        (op_q == bsio_pkg::set_one_op) ||
                        (op_q == bsio_pkg::set_zero_op);
  assign is_single_op = (cmd.op == bsio_pkg::set_one_op) ||
                        (cmd.op == bsio_pkg::set_zero_op) ||
                        (cmd.op == bsio_pkg::test_bit_op);
  // Bits 0-2 and 15 of the base register are simply not selected
  assign hw_base = cmd.io_base_register[bsio_pkg::BSIO_BASE_MSB:bsio_pkg::BSIO_BASE_LSB]; // [R3]
  assign disp_ext = {{4{cmd.disp[7]}}, cmd.disp}; // [R17]
  // A count of zero stands for sixteen bits
  assign next_byte_mode = (cmd.count != 4'h0) && (cmd.count <= bsio_pkg::BSIO_BYTE_MAX_COUNT);
  assign next_last_k = (cmd.count == 4'h0) ? bsio_pkg::BSIO_FULL_LAST_BIT :
                       {1'b0, cmd.count - 4'h1};

  // Bit that the current slot captures, placed at its word position
  always_comb begin
    next_collect = collect;
    next_collect[bsio_pkg::bsio_bit_index(byte_mode, bit_k)] = sin_s; // [R10]
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      phase <= 3'h0;
      cmd_ready <= 1'b1;
      busy <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            state <= ST_SLOT;
            phase <= 3'h0;
            cmd_ready <= 1'b0;
            busy <= 1'b1;
          end
        end
        ST_SLOT: begin
          // Each bit slot is two clock cycles of four phases
          if (phase == bsio_pkg::BSIO_SLOT_LAST_PHASE) begin // [R5]
            phase <= 3'h0;
            if (last_bit) begin
              state <= ST_IDLE;
              cmd_ready <= 1'b1;
              busy <= 1'b0;
            end
          end else begin
            phase <= phase + 3'h1;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Address lines
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      io_addr <= bsio_pkg::BSIO_ADDR_RESET;
    end else if (accept) begin
      if (is_single_op) begin
        io_addr <= {bsio_pkg::BSIO_ADDR_HIGH_ZERO, hw_base + disp_ext}; // [R1] [R2]
      end else begin
        io_addr <= {bsio_pkg::BSIO_ADDR_HIGH_ZERO, hw_base}; // [R4] [R2]
      end
    end else if (slot_end && !last_bit) begin
      // Held through the whole slot, stepped only at its end
      // Twelve-bit adder wraps at the top of the bit space
      io_addr <= {bsio_pkg::BSIO_ADDR_HIGH_ZERO, io_addr[11:0] + 12'h001}; // [R8] [R5]
    end
  end

  // ****************************************
  // Transfer bookkeeping
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      op_q <= bsio_pkg::multibit_load_op;
      bit_k <= 5'h00;
      last_k <= 5'h00;
      byte_mode <= 1'b0;
      word_q <= bsio_pkg::BSIO_WORD_RESET;
      collect <= bsio_pkg::BSIO_WORD_RESET;
    end else if (accept) begin
      op_q <= cmd.op;
      bit_k <= 5'h00;
      last_k <= is_single_op ? 5'h00 : next_last_k;
      byte_mode <= next_byte_mode;
      word_q <= cmd.load_word;
      // Unused bits start at zero; a byte transfer keeps the right byte
      collect <= next_byte_mode ? {8'h00, cmd.dest_word[7:0]} : 16'h0000; // [R12]
    end else if (slot_end) begin
      // Also steps past the last bit; harmless, reloaded on the next accept
      bit_k <= next_k;
      if (op_q == bsio_pkg::multibit_store_op) begin
        collect <= next_collect;
      end
    end
  end

  // ****************************************
  // Serial output and strobe
  // ****************************************
  // Level holds after the op ends, so a set op leaves its value on the line
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      serial_output_line <= 1'b0;
    end else if (accept) begin
      unique case (cmd.op)
        bsio_pkg::multibit_load_op: begin
          serial_output_line <=
            cmd.load_word[bsio_pkg::bsio_bit_index(next_byte_mode, 5'h00)]; // [R9] [R11]
        end
        bsio_pkg::set_one_op: serial_output_line <= 1'b1; // [R13]
        bsio_pkg::set_zero_op: serial_output_line <= 1'b0; // [R14]
        default: serial_output_line <= 1'b0;
      endcase
    end else if (slot_end && !last_bit && (op_q == bsio_pkg::multibit_load_op)) begin
      serial_output_line <= word_q[bsio_pkg::bsio_bit_index(byte_mode, next_k)]; // [R9]
    end
  end

  // Strobe runs only for output ops so input devices never see a write pulse
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      output_bit_strobe <= 1'b0;
    end else if ((state == ST_SLOT) && is_output_op &&
                 (phase == bsio_pkg::BSIO_STROBE_ON_PHASE)) begin
      output_bit_strobe <= 1'b1; // [R6]
    end else if (phase == bsio_pkg::BSIO_STROBE_OFF_PHASE) begin
      output_bit_strobe <= 1'b0; // [R6]
    end
  end

  // ****************************************
  // Completion and results
  // ****************************************
  // Sampling on the slot's last phase lands between phase four and the next phase one
  // Flag holds between test ops; only a test op can move it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= slot_end && last_bit;
      if (slot_end && last_bit && (op_q == bsio_pkg::multibit_store_op)) begin
        result.word <= next_collect; // [R7] [R10] [R12]
      end
      if ((phase == bsio_pkg::BSIO_SAMPLE_PHASE) && (state == ST_SLOT) &&
          (op_q == bsio_pkg::test_bit_op)) begin
        result.equal_status_flag <= sin_s; // [R15] [R7]
      end
    end
  end

endmodule

// *** shared/bsio_pkg.sv ***
// What this block does
// [R1] Single-bit address is base bits 3-14 plus the sign-extended 8-bit displacement.
// [R2] Address appears on lines A3-A14; lines A0, A1, A2 stay at zero.
// [R3] Base register bits 0, 1, 2 and 15 never reach the address.
// [R4] Multibit transfers start at the hardware base address with no displacement.
// [R5] Address is valid from phase two and holds for eight phases.
// [R6] Output strobe rises at the following phase two, high for two phases.
// [R7] Input transfers sample the serial input between phase four and phase one.
// [R8] Multibit transfers step the address by one per bit until done.
// [R9] Multibit load sends 1 to 16 bits out on the serial output.
// [R10] Multibit store gathers 1 to 16 input bits into one word.
// [R11] Counts 1-8 use the left byte, starting at bit 7, then bit 6.
// [R12] Store zeroes unused bits; byte-length store keeps the right byte.
// [R13] Set-one drives a one on the serial output at base plus displacement.
// [R14] Set-zero drives a zero on the serial output at base plus displacement.
// [R15] Test-bit samples the serial input into the equal status flag.
// [R16] Software steps to the next 16-bit block by adding 0020 hex to base.
// [R17] Displacement is signed, -128 to +127, before the addition.
// [R18] Peripherals drive input bits without any strobe.
// [R19] Counts 9-16 use the whole word, starting at bit 15.
package bsio_pkg;

  // ****************************************
  // Timing, counted in clock phases
  // ****************************************
  localparam logic [2:0] BSIO_SLOT_LAST_PHASE = 3'h7;
  localparam logic [2:0] BSIO_STROBE_ON_PHASE = 3'h3;
  localparam logic [2:0] BSIO_STROBE_OFF_PHASE = 3'h5;
  localparam logic [2:0] BSIO_SAMPLE_PHASE = 3'h7;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int BSIO_BASE_LSB = 1;
  localparam int BSIO_BASE_MSB = 12;
  localparam logic [3:0] BSIO_BYTE_MAX_COUNT = 4'h8;
  localparam logic [4:0] BSIO_BYTE_FIRST_BIT = 5'h08;
  localparam logic [4:0] BSIO_FULL_LAST_BIT = 5'h0F;
  localparam logic [2:0] BSIO_ADDR_HIGH_ZERO = 3'h0;
  localparam logic [14:0] BSIO_ADDR_RESET = 15'h0000;
  localparam logic [15:0] BSIO_WORD_RESET = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    multibit_load_op,
    multibit_store_op,
    set_one_op,
    set_zero_op,
    test_bit_op
  } bsio_op_t;

  typedef struct packed {
    bsio_op_t op;
    logic [15:0] io_base_register;
    logic [7:0] disp;
    logic [3:0] count;
    logic [15:0] load_word;
    logic [15:0] dest_word;
  } bsio_cmd_t;

  typedef struct packed {
    logic [15:0] word;
    logic equal_status_flag;
  } bsio_result_t;

  // Bit k of a transfer in vector order (word bit n, counted from the MSB, is vector bit 15-n)
  function automatic logic [3:0] bsio_bit_index(input logic byte_mode, input logic [4:0] k);
    logic [4:0] idx;
    idx = byte_mode ? (BSIO_BYTE_FIRST_BIT + k) : k; // [R11] [R19]
    return idx[3:0];
  endfunction

endpackage

// *** rtl/bsio_sync.sv ***
`timescale 1ns/10ps
module bsio_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ****************************************
  // Two-flop synchroniser
  // ****************************************
  // Only the second flop reads stage1
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule

// *** bench/bsio_unit_chk.sv ***
`timescale 1ns/10ps
module bsio_unit_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire bsio_pkg::bsio_cmd_t cmd,
  input wire logic serial_input_line,
  input wire logic cmd_ready,
  input wire logic busy,
  input wire logic [14:0] io_addr,
  input wire logic serial_output_line,
  input wire logic output_bit_strobe,
  input wire logic done,
  input wire bsio_pkg::bsio_result_t result
);
  logic [11:0] base_a;
  logic [11:0] sum_a;
  logic take;
  logic single;
  logic outp;
  assign base_a = cmd.io_base_register[12:1];
  assign sum_a = base_a + {{4{cmd.disp[7]}}, cmd.disp};
  assign take = cmd_valid && cmd_ready;
  assign single = cmd.op > bsio_pkg::multibit_store_op;
  assign outp = cmd.op != bsio_pkg::multibit_store_op && cmd.op != bsio_pkg::test_bit_op;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_high_zero: assert property (io_addr[14:12] == 3'h0)
    else $error("upper address lines not zero");
  chk_single_addr: assert property (take && single |=> io_addr[11:0] == $past(sum_a))
    else $error("single bit address wrong");
  chk_multi_addr: assert property (take && !single |=> io_addr[11:0] == $past(base_a))
    else $error("multibit start address wrong");
  chk_addr_hold: assert property ($rose(busy) |=> $stable(io_addr)[*7])
    else $error("address not held for the slot");
  chk_addr_step: assert property (busy && !$rose(busy) && $changed(io_addr)
    |-> io_addr[11:0] == $past(io_addr[11:0]) + 12'h001)
    else $error("address step not one");
  chk_strobe_out: assert property (take && outp |=> !output_bit_strobe[*4]
    ##1 output_bit_strobe[*2] ##1 !output_bit_strobe)
    else $error("strobe timing wrong");
  chk_no_strobe_in: assert property (take && !outp |=> !output_bit_strobe[*8])
    else $error("strobe on input transfer");
  chk_set_one: assert property (take && cmd.op == bsio_pkg::set_one_op
    |=> serial_output_line[*8])
    else $error("set one level wrong");
  chk_set_zero: assert property (take && cmd.op == bsio_pkg::set_zero_op
    |=> !serial_output_line[*8])
    else $error("set zero level wrong");
  chk_done_single: assert property (take && single |=> !done[*8] ##1 done)
    else $error("single op end timing wrong");
  cover property (take && cmd.op == bsio_pkg::multibit_load_op);
  cover property (take && cmd.op == bsio_pkg::multibit_store_op);
  cover property (take && cmd.op == bsio_pkg::test_bit_op);
endmodule

bind bsio_unit bsio_unit_chk bsio_unit_chk_i (.mclk(mclk), .rst_b(rst_b),
  .cmd_valid(cmd_valid), .cmd(cmd), .serial_input_line(serial_input_line),
  .cmd_ready(cmd_ready), .busy(busy), .io_addr(io_addr),
  .serial_output_line(serial_output_line), .output_bit_strobe(output_bit_strobe),
  .done(done), .result(result));

// *** bench/bsio_periph.sv ***
`timescale 1ns/10ps
module bsio_periph #(
  parameter logic [7:0] PAGE = 8'h12
) (
  input wire logic mclk,
  input wire logic [14:0] io_addr,
  input wire logic serial_output_line,
  input wire logic output_bit_strobe,
  output logic serial_input_line
);
  logic [15:0] mem = 16'h0000;
  logic sel;
  assign sel = io_addr[14:4] == {3'h0, PAGE};
  // Unselected: shows the inverse of the addressed bit, so a decode slip reads wrong data
  assign serial_input_line = sel ? mem[io_addr[3:0]] : ~mem[io_addr[3:0]];
  always @(posedge mclk) begin
    if (output_bit_strobe && sel) begin
      mem[io_addr[3:0]] <= serial_output_line;
    end
  end
endmodule

// *** bench/tb_bsio_unit.sv ***
`timescale 1ns/10ps
module tb_bsio_unit;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  bsio_pkg::bsio_cmd_t cmd = '0;
  logic serial_input_line;
  logic cmd_ready;
  logic busy;
  logic [14:0] io_addr;
  logic serial_output_line;
  logic output_bit_strobe;
  logic done;
  bsio_pkg::bsio_result_t result;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;

  always #10 mclk = ~mclk;

  bsio_unit bsio_unit_i (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
    .serial_input_line(serial_input_line), .cmd_ready(cmd_ready), .busy(busy),
    .io_addr(io_addr), .serial_output_line(serial_output_line),
    .output_bit_strobe(output_bit_strobe), .done(done), .result(result));
  bsio_periph bsio_periph_i (.mclk(mclk), .io_addr(io_addr),
    .serial_output_line(serial_output_line), .output_bit_strobe(output_bit_strobe),
    .serial_input_line(serial_input_line));

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Called at a falling edge; returns at the falling edge inside the done cycle
  task automatic op_run(input bsio_pkg::bsio_op_t o, input logic [15:0] b,
    input logic [7:0] d, input logic [3:0] n = 4'h0, input logic [15:0] lw = 16'h0000,
    input logic [15:0] dw = 16'h0000);
    int i;
    cmd = '{o, b, d, n, lw, dw};
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    i = 0;
    while (done !== 1'b1 && i < 200) begin
      @(negedge mclk);
      i++;
    end
    if (i == 200) begin
      error_cnt++;
      $display("unexpected at %0t: no done", $time);
    end
  endtask

  task automatic t_load_word();
    op_run(bsio_pkg::multibit_load_op, 16'h0240, 8'h33, 4'h0, 16'hA5C3);
    cmp(bsio_periph_i.mem, 16'hA5C3);
  endtask

  task automatic t_store_word();
    op_run(bsio_pkg::multibit_store_op, 16'h0240, 8'h00, 4'h0, 16'h0000, 16'h1234);
    cmp(result.word, 16'hA5C3);
  endtask

  task automatic t_byte_ops();
    op_run(bsio_pkg::multibit_load_op, 16'h0240, 8'h05, 4'h3, 16'h0500);
    cmp(bsio_periph_i.mem, 16'hA5C5);
    op_run(bsio_pkg::multibit_store_op, 16'h0242, 8'h00, 4'h2, 16'h0000, 16'hFFAA);
    cmp(result.word, 16'h02AA);
    op_run(bsio_pkg::multibit_store_op, 16'h0240, 8'h00, 4'hA, 16'h0000, 16'hFFFF);
    cmp(result.word, 16'h01C5);
  endtask

  task automatic t_single_ops();
    op_run(bsio_pkg::set_one_op, 16'hE261, 8'hF5);
    op_run(bsio_pkg::set_zero_op, 16'h0240, 8'h07);
    cmp(bsio_periph_i.mem, 16'hA565);
    op_run(bsio_pkg::test_bit_op, 16'h0340, 8'h80);
    cmp({15'h0000, result.equal_status_flag}, 16'h0001);
    op_run(bsio_pkg::test_bit_op, 16'h014C, 8'h7F);
    cmp({15'h0000, result.equal_status_flag}, 16'h0001);
    op_run(bsio_pkg::test_bit_op, 16'h0240, 8'h07);
    cmp({15'h0000, result.equal_status_flag}, 16'h0000);
    // One block below, displacement climbs back to the same bit
    op_run(bsio_pkg::test_bit_op, 16'h0240 - 16'h0020, 8'h10);
    cmp({15'h0000, result.equal_status_flag}, 16'h0001);
  endtask

  // Whole run is a few hundred cycles; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("unexpected at %0t: timeout", $time);
      summarize();
    end
  end

  initial begin
    repeat (20) @(negedge mclk);
    rst_b = 1'b1;
    t_load_word();
    t_store_word();
    t_byte_ops();
    t_single_ops();
    summarize();
  end
endmodule
